// >>> rtl/pssbp_pkg.sv
// constants, types and the burst address function of the sram burst port
// assumes one 10 MHz clock and a synchronous active-high reset
package pssbp_pkg;
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int DATA_W = 32;
	localparam int WORD_W = 36;
	localparam int PAR_LSB = 32;
	localparam int SYNC_STAGES = 2;
	// cycle types held between a begin-burst and its continue cycles
	typedef enum logic [1:0] {
		PSSBP_DESELECT = 2'b00,
		PSSBP_READ = 2'b01,
		PSSBP_WRITE = 2'b10
	} pssbp_state_t;
	// register map, byte offsets on the ahb-lite port
	localparam logic [11:0] OFF_CONFIG = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam int CFG_PARITY_BIT = 0;
	localparam int CFG_TWO_LANE_BIT = 1;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;
	localparam logic [31:0] CFG_MASK = 32'h0000_0003;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_STEP_LSB = 2;
	localparam int ST_SLEEP_BIT = 4;
	localparam int ST_DRIVE_BIT = 5;
	localparam int ST_STALL_BIT = 6;
	localparam logic [3:0] LANE_MASK_ALL = 4'hf;
	localparam logic [3:0] LANE_MASK_TWO = 4'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	// low address bits of burst step 'step' from the loaded seed
	function automatic logic [1:0] pssbp_burst_addr(input logic [1:0] seed,
		input logic [1:0] step, input logic interleaved);
		if (interleaved) begin
			return seed ^ step;
		end
		return 2'(seed + step);
	endfunction : pssbp_burst_addr
endpackage : pssbp_pkg

// >>> rtl/pssbp_ifs.sv
// interfaces between the sram port core, its burst counter and its registers
// assumes all parties sit on the same clock
`timescale 1ns/1ns
interface pssbp_burst_if;
	logic load;
	logic advance;
	logic order;
	logic [1:0] seed;
	logic [1:0] step;
	logic [1:0] next_low;
	modport counter(input load, input advance, input order, input seed,
		output step, output next_low);
	modport user(output load, output advance, output order, output seed,
		input step, input next_low);
endinterface : pssbp_burst_if

interface pssbp_csr_if;
	logic [31:0] cfg;
	logic [31:0] status;
	modport regs(output cfg, input status);
	modport core(input cfg, output status);
endinterface : pssbp_csr_if

// >>> rtl/pssbp_burst.sv
// two-bit burst counter: seed on load, step on advance
// assumes load and advance are already gated by the clock enable
`timescale 1ns/1ns
module pssbp_burst
	import pssbp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	pssbp_burst_if.counter bus
);
	logic [1:0] seed_r;
	logic [1:0] step_r;

	// step wraps after four, so the fifth burst cycle returns to the seed
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			seed_r <= '0;
			step_r <= '0;
		end else if (bus.load) begin
			seed_r <= bus.seed;
			step_r <= '0;
		end else if (bus.advance) begin
			step_r <= 2'(step_r + 2'b01);
		end
	end

	// address of the next step, looked at by the core on advance cycles
	assign bus.step = step_r;
	assign bus.next_low = pssbp_burst_addr(seed_r, 2'(step_r + 2'b01),
		bus.order);
endmodule : pssbp_burst

// >>> rtl/pssbp_regs.sv
// ahb-lite slave with the organisation config and a status readback
// assumes a single master, zero wait states, word accesses
`timescale 1ns/1ns
module pssbp_regs
	import pssbp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	pssbp_csr_if.regs csr
);
	logic accept;
	logic wr_pend_r;
	logic [11:0] wr_off_r;
	logic [31:0] cfg_r;
	logic [31:0] hrdata_r;
	logic cfg_wr;

	// nonseq or seq counts; only upper address bits above 11 alias
	assign accept = i_hsel & i_hready & i_htrans[1];
	assign cfg_wr = wr_pend_r & i_hready & (wr_off_r == OFF_CONFIG);

	// address phase of a write is remembered for its data phase
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_pend_r <= 1'b0;
			wr_off_r <= '0;
		end else if (i_hready) begin
			wr_pend_r <= accept & i_hwrite & (i_hsize == HSIZE_WORD);
			wr_off_r <= i_haddr[11:0];
		end
	end

	// config steers the organisation of the data lanes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_r <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg_r <= i_hwdata & CFG_MASK;
		end
	end

	// read data captured at the address phase; a write still in its data
	// phase is forwarded so a back-to-back read sees the new value
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hrdata_r <= '0;
		end else if (accept && !i_hwrite) begin
			case (i_haddr[11:0])
				OFF_CONFIG: hrdata_r <= cfg_wr ? (i_hwdata & CFG_MASK) : cfg_r;
				OFF_STATUS: hrdata_r <= csr.status;
				default: hrdata_r <= '0;
			endcase
		end
	end

	assign csr.cfg = cfg_r;
	assign o_hrdata = hrdata_r;
	assign o_hreadyout = 1'b1;
	assign o_hresp = HRESP_OKAY;
endmodule : pssbp_regs

// >>> rtl/pssbp_top.sv
// pipelined synchronous sram port: command decode, burst, array, bus drive
// assumes host inputs are aligned to i_clk; drive enable and sleep are not
// Summary of operation
// - order high: later burst addresses are seed xor step one, two, three.
// - order low: later burst addresses count up by one, wrapping at four.
// - two-bit counter seeded from low address, back to seed every fourth.
// - every continue-burst cycle of a read or write burst advances the address counter.
// - continue cycles ignore read/write and repeat the begin-burst type.
// - advance after deselect stays deselected; bus stays off.
// - read with drive off leaves bus off; write with no lanes writes nothing.
// - write cycles never drive the data bus.
// - stalled edge keeps read drive, keeps write off, writes nothing.
// - stalled edge leaves state, counter and pipeline unchanged.
// - state changes only on rising clock edges.
// - write only lanes whose active-low enable is low; any mix allowed.
// - each lane enable steers its own data lane; two-lane mode has a, b.
// - parity bit per lane in 36-bit mode; none in 32-bit mode.
// - data bus off from reset until a read drives it.
// - all inputs but drive enable and sleep are sampled on the edge.
// - load registers address and type; advance steps the counter.
// - selects sampled on load; all three active or the cycle deselects.
// - sleep ignores inputs, floats outputs, keeps array contents.
`timescale 1ns/1ns
module pssbp_top
	import pssbp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_load_or_advance_n,
	input wire logic i_read_write_n,
	input wire logic i_chip_select_n,
	input wire logic i_select_depth_low_n,
	input wire logic i_select_depth_high,
	input wire logic i_lane_a_write_en_n,
	input wire logic i_lane_b_write_en_n,
	input wire logic i_lane_c_write_en_n,
	input wire logic i_lane_d_write_en_n,
	input wire logic i_clock_enable_n,
	input wire logic i_output_drive_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order_select,
	input wire logic [DATA_W-1:0] i_data_lanes,
	output logic [DATA_W-1:0] o_data_lanes,
	output logic [LANES-1:0] o_data_lanes_oe,
	input wire logic [LANES-1:0] i_parity_lanes,
	output logic [LANES-1:0] o_parity_lanes,
	output logic [LANES-1:0] o_parity_lanes_oe,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp
);
	logic [WORD_W-1:0] mem [2**ADDR_W];
	logic [SYNC_STAGES-1:0] sleep_sync_r;
	logic [SYNC_STAGES-1:0] drive_sync_r;
	logic sleep_s;
	logic drive_off_s;
	logic en;
	logic par_on;
	logic [LANES-1:0] lane_mask;
	logic [LANES-1:0] write_en;
	logic selected;
	logic is_load;
	pssbp_state_t state_r;
	logic [ADDR_W-3:0] hi_r;
	logic iss_valid;
	logic iss_read;
	logic [ADDR_W-1:0] iss_addr;
	logic s1_valid_r;
	logic s1_read_r;
	logic [ADDR_W-1:0] s1_addr_r;
	logic [LANES-1:0] s1_be_r;
	logic s2_wr_r;
	logic [ADDR_W-1:0] s2_addr_r;
	logic [LANES-1:0] s2_be_r;
	logic mem_we;
	logic drive_r;
	logic drive_now;
	logic [WORD_W-1:0] rd_word_r;
	logic [WORD_W-1:0] rd_nxt;

	pssbp_burst_if bif();
	pssbp_csr_if csr();

	pssbp_burst u_burst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.bus(bif.counter)
	);

	pssbp_regs u_regs (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.o_hrdata(o_hrdata),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.csr(csr.regs)
	);

	// drive enable and sleep are asynchronous pins: two flops first;
	// drive enable resets to 'off' so the bus floats from reset on
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sleep_sync_r <= '0;
			drive_sync_r <= '1;
		end else begin
			sleep_sync_r <= {sleep_sync_r[0], i_sleep_request};
			drive_sync_r <= {drive_sync_r[0], i_output_drive_n};
		end
	end
	assign sleep_s = sleep_sync_r[SYNC_STAGES-1];
	assign drive_off_s = drive_sync_r[SYNC_STAGES-1];

	// a stalled or sleeping edge is simply not an edge for the core
	assign en = !i_clock_enable_n && !sleep_s;
	assign par_on = csr.cfg[CFG_PARITY_BIT];
	assign lane_mask = csr.cfg[CFG_TWO_LANE_BIT] ? LANE_MASK_TWO
		: LANE_MASK_ALL;
	assign write_en = ~{i_lane_d_write_en_n, i_lane_c_write_en_n,
		i_lane_b_write_en_n, i_lane_a_write_en_n} & lane_mask;
	assign selected = !i_chip_select_n && !i_select_depth_low_n
		&& i_select_depth_high;
	assign is_load = !i_load_or_advance_n;

	// burst counter control; advance after a deselect is a no-op
	assign bif.load = en && is_load && selected;
	assign bif.advance = en && !is_load && (state_r != PSSBP_DESELECT);
	assign bif.seed = i_addr[1:0];
	assign bif.order = i_burst_order_select;

	// the access this edge launches; continue cycles reuse the held type
	assign iss_valid = bif.load || bif.advance;
	assign iss_read = is_load ? i_read_write_n
		: (state_r == PSSBP_READ);
	assign iss_addr = is_load ? i_addr : {hi_r, bif.next_low};

	// operating state, taken only on enabled rising edges of a load
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= PSSBP_DESELECT;
		end else if (en && is_load) begin
			if (!selected) begin
				state_r <= PSSBP_DESELECT;
			end else if (i_read_write_n) begin
				state_r <= PSSBP_READ;
			end else begin
				state_r <= PSSBP_WRITE;
			end
		end
	end

	// upper address bits stay with the burst
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hi_r <= '0;
		end else if (bif.load) begin
			hi_r <= i_addr[ADDR_W-1:2];
		end
	end

	// first pipeline stage: address and byte enables of the launched cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_valid_r <= 1'b0;
			s1_read_r <= 1'b0;
			s1_addr_r <= '0;
			s1_be_r <= '0;
		end else if (en) begin
			s1_valid_r <= iss_valid;
			s1_read_r <= iss_read;
			s1_addr_r <= iss_addr;
			s1_be_r <= write_en;
		end
	end

	// second stage of a write waits for its data one edge later
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s2_wr_r <= 1'b0;
			s2_addr_r <= '0;
			s2_be_r <= '0;
		end else if (en) begin
			s2_wr_r <= s1_valid_r && !s1_read_r;
			s2_addr_r <= s1_addr_r;
			s2_be_r <= s1_be_r;
		end
	end

	// write commits two enabled edges after its address; lanes not enabled
	// keep their contents, and a stall or sleep commits nothing
	assign mem_we = en && s2_wr_r;
	always_ff @(posedge i_clk) begin
		for (int g = 0; g < LANES; g++) begin
			if (mem_we && s2_be_r[g]) begin
				mem[s2_addr_r][8*g +: 8] <= i_data_lanes[8*g +: 8];
				if (par_on) begin
					mem[s2_addr_r][PAR_LSB+g] <= i_parity_lanes[g];
				end
			end
		end
	end

	// array read with bypass of a write committing on the same edge,
	// otherwise a read straight after a write would return stale data
	always_comb begin
		rd_nxt = mem[s1_addr_r];
		for (int g = 0; g < LANES; g++) begin
			if (mem_we && s2_be_r[g] && (s2_addr_r == s1_addr_r)) begin
				rd_nxt[8*g +: 8] = i_data_lanes[8*g +: 8];
				rd_nxt[PAR_LSB+g] = i_parity_lanes[g];
			end
		end
		if (!par_on) begin
			rd_nxt[WORD_W-1:PAR_LSB] = '0;
		end
	end

	// output register; holds through stalls so a read stays driven
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			drive_r <= 1'b0;
			rd_word_r <= '0;
		end else if (en) begin
			drive_r <= s1_valid_r && s1_read_r;
			if (s1_valid_r && s1_read_r) begin
				rd_word_r <= rd_nxt;
			end
		end
	end

	// drive enable pin only ever narrows the device's own decision
	assign drive_now = drive_r && !drive_off_s && !sleep_s;
	assign o_data_lanes = rd_word_r[DATA_W-1:0];
	assign o_parity_lanes = rd_word_r[WORD_W-1:PAR_LSB];
	assign o_data_lanes_oe = drive_now ? lane_mask : '0;
	assign o_parity_lanes_oe = (drive_now && par_on) ? lane_mask : '0;

	assign csr.status = {25'h000_0000, !en, drive_now, sleep_s, bif.step,
		state_r};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_burst_interleave: assert property ((en && bif.load && bif.order) ##1
		(en && bif.advance) |-> iss_addr[1:0] ==
		($past(i_addr[1:0]) ^ 2'b01))
		else $error("interleaved second burst address wrong");
	a_burst_linear: assert property ((en && bif.load && !bif.order) ##1
		(en && bif.advance)[*2] |-> iss_addr[1:0] ==
		2'($past(i_addr[1:0], 2) + 2'b10))
		else $error("linear third burst address wrong");
	a_burst_wrap: assert property ((en && bif.load) ##1
		(en && bif.advance)[*4] |->
		iss_addr[1:0] == $past(iss_addr[1:0], 4))
		else $error("burst does not return to seed on fourth step");
	a_burst_step: assert property (en && bif.advance |=>
		bif.step == 2'($past(bif.step) + 2'b01))
		else $error("counter not advanced on continue cycle");
	a_type_kept: assert property (en && bif.advance |=>
		state_r == $past(state_r) &&
		s1_read_r == ($past(state_r) == PSSBP_READ))
		else $error("continue cycle changed its type");
	a_cont_desel: assert property (en && !is_load &&
		state_r == PSSBP_DESELECT |=> state_r == PSSBP_DESELECT
		&& !s1_valid_r ##1 o_data_lanes_oe == '0)
		else $error("advance after deselect launched an access");
	a_abort_none: assert property ((en && iss_valid && !iss_read &&
		write_en == '0) ##1 en |=> !(s2_wr_r && (s2_be_r != '0)))
		else $error("write abort enabled a lane");
	a_write_float: assert property (s2_wr_r |->
		o_data_lanes_oe == '0 && o_parity_lanes_oe == '0)
		else $error("bus driven during write data cycle");
	a_stall_hold: assert property (!en |=> $stable(state_r) &&
		$stable(drive_r) && $stable(s1_addr_r) && $stable(bif.step)
		&& $stable(o_data_lanes))
		else $error("stalled edge changed device state");
	a_stall_nowrite: assert property (i_clock_enable_n |-> !mem_we)
		else $error("write performed on a stalled edge");
	a_lane_write: assert property (mem_we && s2_be_r[0] |=>
		mem[$past(s2_addr_r)][7:0] == $past(i_data_lanes[7:0]))
		else $error("lane a write not stored");
	a_float_idle: assert property (!drive_r |->
		o_data_lanes_oe == '0)
		else $error("bus driven with no read data");
	a_desel_load: assert property (en && is_load && !selected |=>
		state_r == PSSBP_DESELECT && !s1_valid_r)
		else $error("unselected load not a deselect");
	a_sleep_float: assert property (sleep_s |->
		o_data_lanes_oe == '0 && !mem_we && !iss_valid)
		else $error("sleep did not float or ignore inputs");
	a_read_latency: assert property ((en && iss_valid && iss_read) ##1 en
		|=> drive_r)
		else $error("read data not ready after next enabled edge");

	c_read_burst: cover property ((en && bif.load && i_read_write_n)
		##1 (en && bif.advance)[*3]);
	c_write_then_read: cover property ((en && bif.load && !i_read_write_n)
		##1 (en && bif.load && i_read_write_n));
	c_stall_read: cover property (drive_now ##1 !en ##1 drive_now);
	c_sleep: cover property ($rose(sleep_s));
endmodule : pssbp_top

// >>> dv/pssbp_host.sv
// host memory controller model: issues commands, mirrors the two-stage
// pipeline, supplies write data and resolves the shared data wires
// assumes cmd() is called from one bench process, once per cycle
`timescale 1ns/1ns
module pssbp_host
	import pssbp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [DATA_W-1:0] i_dq_dev,
	input wire logic [LANES-1:0] i_dq_oe,
	input wire logic [LANES-1:0] i_dqp_dev,
	input wire logic [LANES-1:0] i_dqp_oe,
	output logic [9:0] o_ctl,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq,
	output logic [LANES-1:0] o_dqp,
	output logic o_chk,
	output logic [35:0] o_exp,
	output logic [7:0] o_exoe
);
	typedef struct packed {
		logic [1:0] k;
		logic [35:0] d;
		logic [7:0] m;
	} pssbp_stage_t;
	pssbp_stage_t cur, s1_r, s2_r;
	logic [35:0] pat_r = 36'h5_5555_5555;
	logic [35:0] hd;

	// idle is a deselecting load with clock enabled
	initial begin
		o_ctl = 10'h1be;
		o_addr = '0;
		cur = '0;
	end

	// one command per cycle, changed just after the edge
	task automatic cmd(input logic [9:0] c, input logic [ADDR_W-1:0] a,
		input logic [1:0] k, input logic [35:0] d, input logic [7:0] m);
		@(posedge i_clk);
		o_ctl <= c;
		o_addr <= a;
		cur <= '{k: k, d: d, m: m};
	endtask : cmd

	// only enabled edges move the pipeline, as in the device
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else if (!o_ctl[0]) begin
			s1_r <= cur;
			s2_r <= s1_r;
		end
	end

	// released lines toggle so a stale value never looks valid
	always_ff @(posedge i_clk) begin
		pat_r <= ~pat_r;
	end

	// write data stands for the second enabled edge after its address
	assign hd = (s2_r.k == 2'd2) ? s2_r.d : pat_r;
	for (genvar g = 0; g < LANES; g++) begin : g_wire
		assign o_dq[8*g+:8] = i_dq_oe[g] ? i_dq_dev[8*g+:8] : hd[8*g+:8];
		assign o_dqp[g] = i_dqp_oe[g] ? i_dqp_dev[g] : hd[32+g];
	end
	assign o_chk = (s2_r.k == 2'd1);
	assign o_exp = s2_r.d;
	assign o_exoe = o_chk ? s2_r.m : 8'h00;
endmodule : pssbp_host

// >>> dv/tb_pipelined_sync_sram_burst_port.sv
// self-checking bench for the sram burst port and its register slave
// assumes the host model mirrors the pipeline and supplies write data
`timescale 1ns/1ns
module tb_pipelined_sync_sram_burst_port
	import pssbp_pkg::*;
;
	logic clk, rst, drv_n, sleep, order, hsel, hwrite, hready, hresp, chk;
	logic asleep, two, par_on;
	logic [9:0] ctl;
	logic [18:0] addr, seed;
	logic [31:0] dq, dev_dq, haddr, hwdata, hrdata, rd;
	logic [3:0] dq_oe, dqp, dev_dqp, dqp_oe;
	logic [1:0] htrans, st, step;
	logic [2:0] hsize;
	logic [35:0] exp_d;
	logic [7:0] exoe;
	logic [35:0] mem [logic [18:0]];
	int fail_count, checked;

	pssbp_top pssbp_top_inst (.i_clk(clk), .i_rst(rst), .i_addr(addr),
		.i_load_or_advance_n(ctl[9]), .i_read_write_n(ctl[8]),
		.i_chip_select_n(ctl[7]), .i_select_depth_low_n(ctl[6]),
		.i_select_depth_high(ctl[5]), .i_lane_a_write_en_n(ctl[1]),
		.i_lane_b_write_en_n(ctl[2]), .i_lane_c_write_en_n(ctl[3]),
		.i_lane_d_write_en_n(ctl[4]), .i_clock_enable_n(ctl[0]),
		.i_output_drive_n(drv_n), .i_sleep_request(sleep),
		.i_burst_order_select(order), .i_data_lanes(dq),
		.o_data_lanes(dev_dq), .o_data_lanes_oe(dq_oe),
		.i_parity_lanes(dqp), .o_parity_lanes(dev_dqp),
		.o_parity_lanes_oe(dqp_oe), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp));

	pssbp_host pssbp_host_inst (.i_clk(clk), .i_rst(rst),
		.i_dq_dev(dev_dq), .i_dq_oe(dq_oe), .i_dqp_dev(dev_dqp),
		.i_dqp_oe(dqp_oe), .o_ctl(ctl), .o_addr(addr), .o_dq(dq),
		.o_dqp(dqp), .o_chk(chk), .o_exp(exp_d), .o_exoe(exoe));

	// clock at 10 MHz
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [35:0] seen, input logic [35:0] want);
		checked++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	function automatic logic [35:0] msk(input logic [7:0] m);
		for (int g = 0; g < 4; g++) begin
			msk[8*g+:8] = {8{m[g]}};
		end
		msk[35:32] = m[7:4];
	endfunction : msk

	// mid-cycle compare of bus drive and read data against the pipeline
	always @(negedge clk) begin
		check({dqp_oe, dq_oe}, {28'h0, exoe});
		if (chk) begin
			check({dev_dqp, dev_dq} & msk(exoe), exp_d & msk(exoe));
		end
	end

	// one sram command; the model decides type, address and lanes
	task automatic op(input logic ld_n, input logic rw_n,
		input logic [2:0] sel, input logic [3:0] bw,
		input logic [18:0] a, input logic [35:0] wd);
		logic [1:0] k;
		logic [18:0] x;
		logic [3:0] lm;
		logic [7:0] m;
		k = 2'd0;
		x = a;
		lm = two ? 4'h3 : 4'hf;
		if (asleep) begin
			k = 2'd0;
		end else if (!ld_n) begin
			st = (sel != 3'b001) ? 2'd0 : (rw_n ? 2'd1 : 2'd2);
			seed = a;
			step = 2'd0;
			k = st;
		end else if (st != 2'd0) begin
			step = step + 2'd1;
			x = {seed[18:2], order ? seed[1:0] ^ step : seed[1:0] + step};
			k = st;
		end
		for (int g = 0; g < 4; g++) begin
			if (k == 2'd2 && !bw[g] && lm[g]) begin
				mem[x][8*g+:8] = wd[8*g+:8];
				if (par_on) begin
					mem[x][32+g] = wd[32+g];
				end
			end
		end
		m = drv_n ? 8'h00 : {par_on ? lm : 4'h0, lm};
		pssbp_host_inst.cmd({ld_n, rw_n, sel, bw, 1'b0}, a, k,
			(k == 2'd2) ? wd : ((k == 2'd1) ? mem[x] : 36'h0), m);
	endtask : op

	task automatic idle(input int n);
		repeat (n) op(1'b0, 1'b1, 3'b101, 4'hf, 19'h0, 36'h0);
	endtask : idle

	task automatic stall(input int n);
		repeat (n) pssbp_host_inst.cmd({ctl[9:1], 1'b1}, addr, 2'd0,
			36'h0, 8'h00);
	endtask : stall

	// five-beat write and read bursts; rw flipped on advances, stalls inside
	task automatic burst(input logic [18:0] a, input logic [35:0] d);
		op(1'b0, 1'b0, 3'b001, 4'h0, a, d);
		for (int i = 1; i < 5; i++) begin
			op(1'b1, 1'b1, 3'b001, 4'h0, 19'h0, d + 36'(i));
			stall(i % 3);
		end
		op(1'b0, 1'b1, 3'b001, 4'hf, a, 36'h0);
		for (int i = 1; i < 5; i++) begin
			op(1'b1, 1'b0, 3'b001, 4'h0, 19'h0, 36'h0);
			stall(i % 2 * 3);
		end
		// unstalled read burst: the fifth beat is back at the seed
		op(1'b0, 1'b1, 3'b001, 4'hf, a, 36'h0);
		repeat (4) op(1'b1, 1'b0, 3'b001, 4'h0, 19'h0, 36'h0);
		idle(3);
	endtask : burst

	// ahb-lite single word transfer; waits for hready in both phases
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge clk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, a};
		@(posedge clk);
		while (hready !== 1'b1) begin
			@(posedge clk);
		end
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) begin
			@(posedge clk);
		end
		r = hrdata;
		check(36'(hresp), 36'(HRESP_OKAY));
		hsel <= 1'b0;
	endtask : ahb

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// hang guard, well beyond the hundred-odd cycles of the tests
	initial begin
		#2_000_000;
		fail_count++;
		print_verdict();
	end

	initial begin
		{drv_n, sleep, order, asleep, two, par_on} = 6'b001001;
		{hsel, htrans, hwrite, haddr, hwdata} = '0;
		hsize = HSIZE_WORD;
		{st, fail_count, checked, rst} = {2'd0, 32'd0, 32'd0, 1'b1};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// full word, an aborted write, every single lane, reads right after
		op(1'b0, 1'b0, 3'b001, 4'h0, 19'h0_0100, 36'h1_1122_3344);
		op(1'b0, 1'b0, 3'b001, 4'hf, 19'h0_0100, 36'h0_5555_5555);
		op(1'b0, 1'b0, 3'b001, 4'h0, 19'h0_0101, 36'h0);
		for (int g = 0; g < 4; g++) begin
			op(1'b0, 1'b0, 3'b001, ~(4'h1 << g), 19'h0_0101,
				36'(g + 1) << (8 * g));
		end
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0100, 36'h0);
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0101, 36'h0);
		idle(3);
		burst(19'h0_0202, 36'h2_a000_0000);
		// each select off in turn, then an advance that must not write
		for (int i = 0; i < 3; i++) begin
			op(1'b0, 1'b0, 3'b001 ^ (3'b100 >> i), 4'h0, 19'h0_0202, 36'h0);
			op(1'b1, 1'b0, 3'b001, 4'h0, 19'h0, 36'h0);
		end
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0202, 36'h0);
		// the pin passes two flops, so let that read finish driving first
		idle(2);
		drv_n <= 1'b1;
		idle(2);
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0101, 36'h0);
		idle(2);
		drv_n <= 1'b0;
		idle(4);
		ahb(1'b0, 32'(OFF_CONFIG), 32'h0, rd);
		check(36'(rd), 36'(CFG_RESET));
		ahb(1'b1, 32'(OFF_CONFIG), 32'h0000_0002, rd);
		ahb(1'b0, 32'(OFF_CONFIG), 32'h0, rd);
		check(36'(rd), 36'h0_0000_0002);
		ahb(1'b0, 32'h0000_0008, 32'h0, rd);
		check(36'(rd), 36'h0);
		ahb(1'b0, 32'(OFF_STATUS), 32'h0, rd);
		check(36'(rd & 32'h0000_0073), 36'h0);
		{two, par_on} = 2'b10;
		op(1'b0, 1'b0, 3'b001, 4'ha, 19'h0_0100, 36'h1_9999_9999);
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0100, 36'h0);
		idle(3);
		ahb(1'b1, 32'(OFF_CONFIG), CFG_RESET, rd);
		{two, par_on} = 2'b01;
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0100, 36'h0);
		idle(3);
		// sleep: a write issued meanwhile must leave the array alone
		sleep <= 1'b1;
		idle(4);
		asleep = 1'b1;
		op(1'b0, 1'b0, 3'b001, 4'h0, 19'h0_0100, 36'h0);
		asleep = 1'b0;
		sleep <= 1'b0;
		idle(4);
		op(1'b0, 1'b1, 3'b001, 4'h0, 19'h0_0100, 36'h0);
		idle(3);
		// mode pin changes only under a second reset
		rst <= 1'b1;
		order <= 1'b0;
		st = 2'd0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		burst(19'h0_0303, 36'h4_b000_0000);
		print_verdict();
	end
endmodule : tb_pipelined_sync_sram_burst_port
